//--- safety_telegram_pkg.sv
// Purpose: Shared constants for the safety telegram word handler
// Assumes: 16-bit process data words, one telegram per strobe
// Notes: Bit positions and layout codes live here only
`default_nettype none
package safety_telegram_pkg;
  localparam int WORD_W = 16;
  localparam int LAYOUT_W = 10;
  // Telegram layout numbers
  localparam logic [LAYOUT_W-1:0] LAYOUT_SINGLE = 10'h01E;
  localparam logic [LAYOUT_W-1:0] LAYOUT_DOUBLE = 10'h384;
  // Field positions in the command and status words
  localparam int BIT_CUTOFF = 0;
  localparam int BIT_FAULT = 7;
  // Reset values
  localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  // Command word reset keeps torque cutoff selected and ack high
  localparam logic [WORD_W-1:0] COMMAND_RESET = 16'h0080;
  localparam logic [WORD_W-1:0] SECOND_RESET = 16'h0000;
endpackage
`default_nettype wire

//--- safety_telegram_word_handler.sv
// Purpose: Decode safety command words, return safety status words
// Assumes: One telegram presented per i_tlg_valid pulse, synchronous inputs
// Notes: Extended bits of the words are ignored and read back as zero
`timescale 1ns/100ps
`default_nettype none
module safety_telegram_word_handler
  import safety_telegram_pkg::*;
#(
  parameter int FDI_W = 3
)(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [LAYOUT_W-1:0] i_layout,
  input wire logic i_tlg_valid,
  input wire logic i_src_failsafe,
  input wire logic i_src_master,
  input wire logic [WORD_W-1:0] i_safety_command_word,
  input wire logic [WORD_W-1:0] i_second_command_word,
  input wire logic i_fault_detect,
  input wire logic [FDI_W-1:0] i_fdi_state,
  output logic [WORD_W-1:0] o_safety_status_word,
  output logic [WORD_W-1:0] o_input_state_word,
  output logic o_status_valid,
  output logic o_torque_cutoff,
  output logic o_fault_latched,
  output logic o_layout_error
);
  // ---------------------------------------------------------------
  // Telegram acceptance
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_BADLAYOUT} link_state_t;
  link_state_t state;
  link_state_t next_state;
  wire logic is_single = (i_layout == LAYOUT_SINGLE);
  wire logic is_double = (i_layout == LAYOUT_DOUBLE);
  wire logic layout_ok = is_single | is_double;
  // Standard controller or slave-role controller cannot steer safety
  wire logic src_ok = i_src_failsafe & i_src_master;
  wire logic accept = i_tlg_valid & src_ok & layout_ok;
  wire logic bad_layout = i_tlg_valid & src_ok & !layout_ok;
  // Fifth command word holds only reserved bits and is not decoded

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE, ST_BADLAYOUT:
      begin
        if (accept)
          next_state = ST_RUN;
        else if (bad_layout)
          next_state = ST_BADLAYOUT;
      end
      ST_RUN: if (bad_layout) next_state = ST_BADLAYOUT;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic ack_prev;
  wire logic ack_now = i_safety_command_word[BIT_FAULT];
  // Falling edge only; a held zero never acknowledges
  wire logic ack_fall = accept & ack_prev & !ack_now;
  wire logic next_cutoff = accept ? !i_safety_command_word[BIT_CUTOFF] : o_torque_cutoff;
  // Set wins over acknowledge so a fresh fault is never lost
  wire logic next_fault = i_fault_detect | (o_fault_latched & !ack_fall);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack_prev <= COMMAND_RESET[BIT_FAULT];
      o_torque_cutoff <= STATUS_RESET[BIT_CUTOFF];
      o_fault_latched <= STATUS_RESET[BIT_FAULT];
    end
    else
    begin
      if (accept)
      begin
        ack_prev <= ack_now;
      end
      o_torque_cutoff <= next_cutoff;
      o_fault_latched <= next_fault;
    end
  end

  // ---------------------------------------------------------------
  // Status return
  // ---------------------------------------------------------------
  function automatic logic [WORD_W-1:0] pack_status(input logic cutoff, input logic fault);
    logic [WORD_W-1:0] w;
    w = WORD_ZERO;
    w[BIT_CUTOFF] = cutoff;
    w[BIT_FAULT] = fault;
    return w;
  endfunction

  wire logic [WORD_W-1:0] next_status = pack_status(next_cutoff, next_fault);
  wire logic [WORD_W-1:0] fdi_word = {{(WORD_W-FDI_W){1'b0}}, i_fdi_state};

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_safety_status_word <= STATUS_RESET;
      o_input_state_word <= WORD_ZERO;
      o_status_valid <= 1'b0;
      o_layout_error <= 1'b0;
    end
    else
    begin
      o_status_valid <= accept;
      o_layout_error <= (next_state == ST_BADLAYOUT);
      if (accept)
      begin
        o_safety_status_word <= next_status;
        o_input_state_word <= is_double ? fdi_word : WORD_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_status_every;
    @(posedge i_clk_sys) disable iff (!i_rst_n) accept |=> o_status_valid;
  endproperty
  a_status_every: assert property (p_status_every) else $error("no status reply");

  property p_reject_src;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_tlg_valid & !(i_src_failsafe & i_src_master)) |=> !o_status_valid;
  endproperty
  a_reject_src: assert property (p_reject_src) else $error("bad source served");

  property p_cutoff_sel;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      accept |=> (o_torque_cutoff == !$past(i_safety_command_word[BIT_CUTOFF]));
  endproperty
  a_cutoff_sel: assert property (p_cutoff_sel) else $error("cutoff decode wrong");

  property p_status_bits;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_status_valid |-> (o_safety_status_word[BIT_CUTOFF] == o_torque_cutoff)
        && (o_safety_status_word[BIT_FAULT] == o_fault_latched);
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status bits mismatch");

  property p_fault_set;
    @(posedge i_clk_sys) disable iff (!i_rst_n) i_fault_detect |=> o_fault_latched;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_no_ack_held;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_fault_latched & !(accept & ack_prev & !ack_now)) |=> o_fault_latched;
  endproperty
  a_no_ack_held: assert property (p_no_ack_held) else $error("fault cleared w/o edge");

  property p_ack_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (ack_fall & !i_fault_detect) |=> !o_fault_latched;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("edge did not ack");

  property p_fifth_word;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (accept & is_single) |=> (o_input_state_word == WORD_ZERO);
  endproperty
  a_fifth_word: assert property (p_fifth_word) else $error("fifth word in single");

  property p_fdi_copy;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (accept & is_double) |=> (o_input_state_word[FDI_W-1:0] == $past(i_fdi_state));
  endproperty
  a_fdi_copy: assert property (p_fdi_copy) else $error("input states lost");

  property p_layout_flag;
    @(posedge i_clk_sys) disable iff (!i_rst_n) bad_layout |=> o_layout_error;
  endproperty
  a_layout_flag: assert property (p_layout_flag) else $error("layout fault not flagged");

  property p_layout_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_n) accept |=> !o_layout_error;
  endproperty
  a_layout_clear: assert property (p_layout_clear) else $error("layout flag stuck");

  property p_words_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !accept |=> $stable(o_safety_status_word) && $stable(o_input_state_word);
  endproperty
  a_words_hold: assert property (p_words_hold) else $error("words moved w/o telegram");

  property p_cutoff_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n) !accept |=> $stable(o_torque_cutoff);
  endproperty
  a_cutoff_hold: assert property (p_cutoff_hold) else $error("cutoff moved w/o telegram");

  property p_reserved_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_safety_status_word & ~pack_status(1'b1, 1'b1)) == WORD_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

  c_double: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) accept & is_double);
  c_ack: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_fault_latched ##1 ack_fall);
  c_release: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $fell(o_torque_cutoff));
  c_badlayout: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_layout_error);
  c_refused: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) i_tlg_valid & !src_ok);
endmodule
`default_nettype wire

//--- fsc_model.sv
// Purpose: Fail-safe controller model sending safety telegrams
// Assumes: Master role and fail-safe source unless told otherwise
// Notes: Command and layout lines carry inverted values between telegrams; o_cmd2 stays zero
`timescale 1ns/100ps
`default_nettype none
module fsc_model
  import safety_telegram_pkg::*;
(
  input wire logic i_clk_sys,
  output logic [LAYOUT_W-1:0] o_layout,
  output logic o_valid,
  output logic o_failsafe,
  output logic o_master,
  output logic [WORD_W-1:0] o_cmd,
  output logic [WORD_W-1:0] o_cmd2
);
  initial
  begin
    o_layout = LAYOUT_SINGLE;
    o_valid = 1'b0;
    o_failsafe = 1'b1;
    o_master = 1'b1;
    o_cmd = 16'h0001;
    o_cmd2 = WORD_ZERO;
  end
  task automatic send(input logic [LAYOUT_W-1:0] lay, input logic [WORD_W-1:0] cmd,
    input logic fs, input logic ms);
    @(posedge i_clk_sys);
    #2;
    o_layout = lay;
    o_failsafe = fs;
    o_master = ms;
    o_cmd = cmd;
    o_valid = 1'b1;
    @(posedge i_clk_sys);
    #2;
    o_valid = 1'b0;
    // Stale words must not look valid
    o_cmd = ~cmd;
    o_layout = ~lay;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the safety telegram handler
// Assumes: Answer one cycle after an accepted telegram
// Notes: Expected words are hex literals; only the reset checks use the package constants
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import safety_telegram_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fault = 1'b0;
  logic [2:0] fdi = 3'h0;
  logic [LAYOUT_W-1:0] lay;
  logic vld, fs, ms, svld, cut, flt, lerr;
  logic [WORD_W-1:0] cmd, cmd2, stat, inw;
  int fail_count = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  fsc_model ctl (.i_clk_sys(clk), .o_layout(lay), .o_valid(vld), .o_failsafe(fs),
    .o_master(ms), .o_cmd(cmd), .o_cmd2(cmd2));
  safety_telegram_word_handler #(.FDI_W(3)) dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_layout(lay), .i_tlg_valid(vld), .i_src_failsafe(fs), .i_src_master(ms),
    .i_safety_command_word(cmd), .i_second_command_word(cmd2), .i_fault_detect(fault),
    .i_fdi_state(fdi), .o_safety_status_word(stat), .o_input_state_word(inw),
    .o_status_valid(svld), .o_torque_cutoff(cut), .o_fault_latched(flt),
    .o_layout_error(lerr));
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_double();
    fdi = 3'h5;
    ctl.send(LAYOUT_DOUBLE, 16'h0001, 1'b1, 1'b1);
    chk(svld, 16'h0001);
    chk(stat, 16'h0000);
    chk(inw, 16'h0005);
    @(posedge clk);
    #2;
    chk(svld, 16'h0000);
    $display("test double done");
  endtask
  task automatic t_single();
    ctl.send(LAYOUT_SINGLE, 16'h0000, 1'b1, 1'b1);
    chk(stat, 16'h0001);
    chk(inw, 16'h0000);
    chk(cut, 16'h0001);
    $display("test single done");
  endtask
  task automatic t_fault();
    @(posedge clk);
    #2;
    fault = 1'b1;
    @(posedge clk);
    #2;
    fault = 1'b0;
    chk(flt, 16'h0001);
    ctl.send(LAYOUT_SINGLE, 16'h0001, 1'b1, 1'b1);
    chk(stat, 16'h0080);
    ctl.send(LAYOUT_SINGLE, 16'h0081, 1'b1, 1'b1);
    chk(stat, 16'h0080);
    ctl.send(LAYOUT_SINGLE, 16'h0001, 1'b1, 1'b1);
    chk(stat, 16'h0000);
    fault = 1'b1;
    ctl.send(LAYOUT_SINGLE, 16'h0081, 1'b1, 1'b1);
    ctl.send(LAYOUT_SINGLE, 16'h0001, 1'b1, 1'b1);
    fault = 1'b0;
    chk(stat, 16'h0080);
    chk(flt, 16'h0001);
    $display("test fault done");
  endtask
  task automatic t_refuse();
    ctl.send(LAYOUT_DOUBLE, 16'h0000, 1'b0, 1'b1);
    chk({svld, cut}, 16'h0000);
    ctl.send(LAYOUT_DOUBLE, 16'h0000, 1'b1, 1'b0);
    chk({svld, cut}, 16'h0000);
    ctl.send(10'h005, 16'h0000, 1'b1, 1'b1);
    chk({lerr, svld, cut}, 16'h0004);
    $display("test refuse done");
  endtask
  task automatic t_reset();
    @(posedge clk);
    #2;
    rst_n = 1'b0;
    @(posedge clk);
    #2;
    chk(stat, STATUS_RESET);
    chk(inw, WORD_ZERO);
    chk({lerr, svld, flt, cut}, 16'h0001);
    rst_n = 1'b1;
    fault = 1'b1;
    @(posedge clk);
    #2;
    fault = 1'b0;
    chk(flt, 16'h0001);
    ctl.send(LAYOUT_SINGLE, 16'h0001, 1'b1, 1'b1);
    chk(stat, 16'h0000);
    $display("test reset done");
  endtask
  task automatic report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #2;
    chk(stat, STATUS_RESET);
    rst_n = 1'b1;
    t_double();
    t_single();
    t_fault();
    t_refuse();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
